// File: src/port_a_pkg.sv
// constants, types and register map of the port a gpio block
package port_a_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    // register indices
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_DIR = 3'h1;
    localparam logic [2:0] OFF_ANSEL = 3'h2;
    localparam logic [2:0] OFF_PULLUP = 3'h3;
    localparam logic [2:0] OFF_OPTION = 3'h4;
    localparam logic [2:0] OFF_IOC = 3'h5;
    localparam logic [2:0] OFF_BITOP = 3'h6;
    // implemented bit masks
    localparam logic [7:0] PORT_MASK = 8'h00ef;
    localparam logic [7:0] DATA_WR_MASK = 8'h00cf;
    localparam logic [7:0] DIR_WR_MASK = 8'h00cf;
    localparam logic [7:0] DIR_FORCE = 8'h0020;
    localparam logic [3:0] ANSEL_RESET = 4'h000f;
    localparam logic [7:0] PULLUP_MASK = 8'h002f;
    localparam logic [7:0] IOC_MASK = 8'h00f7;
    localparam logic [7:0] ALT1_MASK = 8'h00e7;
    localparam logic [7:0] ALT2_MASK = 8'h0064;
    localparam logic [7:0] DIR_RESET = 8'h00ef;
    localparam logic [7:0] PULLUP_RESET = 8'h002f;
    localparam logic [7:0] IOC_RESET = 8'h0000;
    localparam logic [7:0] LATCH_RESET = 8'h0000;
    localparam int OPT_GPU_BIT = 7;
    localparam logic OPT_GPU_RESET = 1'b1;
    localparam int PIN_MASTER_CLEAR_PIN = 5;
    localparam int PIN_OD = 7;
    localparam int BITOP_VAL = 3;
    localparam int FUSE_MASTER_CLEAR_PIN_BIT = 5;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // per-pin alternate drivers, level 2 outranks level 1
    typedef struct packed {
        logic [7:0] en1;
        logic [7:0] val1;
        logic [7:0] en2;
        logic [7:0] val2;
    } alt_out_t;
endpackage

// File: src/port_a_gpio.sv
// port a gpio: registers, pin drivers, pull-ups and output priority
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module port_a_gpio (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire port_a_pkg::reg_req_t busReq,
    output logic [port_a_pkg::DATA_W-1:0] rdData,
    input wire logic [7:0] fuseWord,
    input wire port_a_pkg::alt_out_t altOut,
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOeN,
    output logic [7:0] pullupOn,
    output logic [7:0] digIn,
    output logic [7:0] changeEnable,
    output logic [3:0] analogMode
);
    import port_a_pkg::*;

    // returns the value of the highest enabled source
    function automatic logic prioSel(input logic portV, input logic e1,
                                     input logic v1, input logic e2,
                                     input logic v2);
        logic r;
        r = portV;
        if (e1) begin
            r = v1;
        end
        if (e2) begin
            r = v2;
        end
        return r;
    endfunction

    logic [7:0] latch_r;
    logic [7:0] dir_r;
    logic [3:0] ansel_r;
    logic [7:0] pullupEn_r;
    logic gpuDisable_r;
    logic [7:0] ioc_r;
    logic [7:0] sync1_r;
    logic [7:0] sync2_r;
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;

    // address decode
    wire wrData = busReq.wr && busReq.addr == OFF_DATA;
    wire wrDir = busReq.wr && busReq.addr == OFF_DIR;
    wire wrAnsel = busReq.wr && busReq.addr == OFF_ANSEL;
    wire wrPullup = busReq.wr && busReq.addr == OFF_PULLUP;
    wire wrOption = busReq.wr && busReq.addr == OFF_OPTION;
    wire wrIoc = busReq.wr && busReq.addr == OFF_IOC;
    wire wrBitop = busReq.wr && busReq.addr == OFF_BITOP;

    // analog mask widened to the port; upper pins are digital only
    wire [7:0] analog8 = {4'h0, ansel_r};

    // synchronised levels, analog pins and the absent bit read as zero
    wire [7:0] pinLevels = sync2_r & ~analog8 & PORT_MASK;

    // direction as seen by software and drivers: pin5 is never an output
    wire [7:0] dirEff = (dir_r | DIR_FORCE) & PORT_MASK;

    // single-bit update built on the pin levels, then stored whole
    wire [2:0] bitSel = busReq.wdata[2:0];
    wire [7:0] bitMask = 8'h0001 << bitSel;
    wire [7:0] bitopVal = busReq.wdata[BITOP_VAL] ?
                          (pinLevels | bitMask) : (pinLevels & ~bitMask);

    // any alternate function claiming a pin
    wire [7:0] altActive = (altOut.en1 & ALT1_MASK) | (altOut.en2 & ALT2_MASK);

    // software-visible read mux, unmapped indices read zero
    always_comb begin
        rdData_nxt = 8'h0000;
        if (busReq.rd) begin
            case (busReq.addr)
                OFF_DATA: rdData_nxt = pinLevels;
                OFF_DIR: rdData_nxt = dirEff;
                OFF_ANSEL: rdData_nxt = {4'h0, ansel_r};
                OFF_PULLUP: rdData_nxt = pullupEn_r;
                OFF_OPTION: rdData_nxt = {gpuDisable_r, 7'h00};
                OFF_IOC: rdData_nxt = ioc_r;
                default: rdData_nxt = 8'h0000;
            endcase
        end
    end

    // two-stage synchroniser on the pad levels
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 8'h0000;
            sync2_r <= 8'h0000;
        end else if (clkEn) begin
            sync1_r <= pinIn;
            sync2_r <= sync1_r;
        end
    end

    // output latch: plain write or pin-based bit update
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_r <= LATCH_RESET;
        end else if (clkEn) begin
            if (wrData) begin
                latch_r <= busReq.wdata & DATA_WR_MASK;
            end else if (wrBitop) begin
                latch_r <= bitopVal & DATA_WR_MASK;
            end
        end
    end

    // direction, analog select and pull-up enables
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dir_r <= DIR_RESET;
            ansel_r <= ANSEL_RESET;
            pullupEn_r <= PULLUP_RESET;
        end else if (clkEn) begin
            if (wrDir) begin
                dir_r <= (busReq.wdata & DIR_WR_MASK) | DIR_FORCE;
            end
            if (wrAnsel) begin
                ansel_r <= busReq.wdata[3:0];
            end
            if (wrPullup) begin
                pullupEn_r <= busReq.wdata & PULLUP_MASK;
            end
        end
    end

    // global pull-up disable and change-interrupt enables
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gpuDisable_r <= OPT_GPU_RESET;
            ioc_r <= IOC_RESET;
        end else if (clkEn) begin
            if (wrOption) begin
                gpuDisable_r <= busReq.wdata[OPT_GPU_BIT];
            end
            if (wrIoc) begin
                ioc_r <= busReq.wdata & IOC_MASK;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdData_r <= 8'h0000;
        end else if (clkEn) begin
            rdData_r <= rdData_nxt;
        end
    end
    assign rdData = rdData_r;

    // per-pin priority mux; analog select does not gate outputs
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            assign pinOut[gi] = prioSel(latch_r[gi],
                                        altOut.en1[gi] & ALT1_MASK[gi],
                                        altOut.val1[gi],
                                        altOut.en2[gi] & ALT2_MASK[gi],
                                        altOut.val2[gi]);
        end
    endgenerate

    // drivers follow the direction bits; the open-drain pin only sinks,
    // so a high value releases it instead of driving the supply
    always_comb begin
        pinOeN = dirEff | ~PORT_MASK;
        pinOeN[PIN_OD] = dirEff[PIN_OD] | pinOut[PIN_OD];
    end

    // weak pull-ups; the master-clear pull-up ignores software
    always_comb begin
        // the global bit is replicated: a bare one-bit term would gate pin 0 only
        pullupOn = {8{~gpuDisable_r}} & ~altActive & dirEff & pullupEn_r
                   & ~analog8 & PULLUP_MASK;
        pullupOn[PIN_MASTER_CLEAR_PIN] = fuseWord[FUSE_MASTER_CLEAR_PIN_BIT];
    end

    // digital inputs for peripherals and the change detector
    assign digIn = pinLevels;
    assign changeEnable = ioc_r & ~analog8;
    assign analogMode = ansel_r;

    // checks on the rules this block keeps

    property p_dir5_reads_one;
        @(posedge clk) disable iff (!resetn)
        (clkEn && busReq.rd && busReq.addr == OFF_DIR) |=> rdData[5];
    endproperty
    a_dir5_reads_one: assert property (p_dir5_reads_one)
        else $error("pin5 direction read back as zero");

    property p_dir_enables_driver;
        @(posedge clk) disable iff (!resetn)
        (clkEn && wrDir && !busReq.wdata[0]) |=> !pinOeN[0];
    endproperty
    a_dir_enables_driver: assert property (p_dir_enables_driver)
        else $error("cleared direction did not enable the driver");

    property p_latch_write;
        @(posedge clk) disable iff (!resetn)
        (clkEn && wrData) |=>
            pinOut[3] == $past(busReq.wdata[3]);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("latch write did not reach pin3 output");

    property p_bitop_store;
        @(posedge clk) disable iff (!resetn)
        (clkEn && wrBitop && busReq.wdata[2:0] == 3'h0) |=>
            latch_r[0] == $past(busReq.wdata[BITOP_VAL]);
    endproperty
    a_bitop_store: assert property (p_bitop_store)
        else $error("bit update stored wrong value");

    property p_analog_reads_zero;
        @(posedge clk) disable iff (!resetn)
        (clkEn && busReq.rd && busReq.addr == OFF_DATA && ansel_r[0])
            |=> !rdData[0];
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero)
        else $error("analog pin read as one");

    property p_sync_latency;
        @(posedge clk) disable iff (!resetn)
        (clkEn && $past(clkEn) && $past(clkEn, 2) && busReq.rd
            && busReq.addr == OFF_DATA) |=> rdData[7:6] == $past(pinIn[7:6], 3);
    endproperty
    a_sync_latency: assert property (p_sync_latency)
        else $error("pin read latency not two stages");

    property p_od_never_high;
        @(posedge clk) disable iff (!resetn)
        !pinOeN[PIN_OD] |-> (!dir_r[PIN_OD]
            && !(altOut.en1[PIN_OD] ? altOut.val1[PIN_OD] : latch_r[PIN_OD]));
    endproperty
    a_od_never_high: assert property (p_od_never_high)
        else $error("open-drain pin drove high");

    property p_pullup_cond;
        @(posedge clk) disable iff (!resetn)
        pullupOn[0] |-> (dirEff[0] && pullupEn_r[0] && !ansel_r[0]
                         && !gpuDisable_r && !altOut.en1[0]);
    endproperty
    a_pullup_cond: assert property (p_pullup_cond)
        else $error("pin0 pull-up on without its conditions");

    property p_no_pullup_upper;
        @(posedge clk) disable iff (!resetn)
        pullupOn[7:6] == 2'b00 && !pullupOn[4];
    endproperty
    a_no_pullup_upper: assert property (p_no_pullup_upper)
        else $error("pull-up on a pin that has none");

    property p_master_clear_pin_pullup;
        @(posedge clk) disable iff (!resetn)
        pullupOn[PIN_MASTER_CLEAR_PIN] == fuseWord[FUSE_MASTER_CLEAR_PIN_BIT];
    endproperty
    a_master_clear_pin_pullup: assert property (p_master_clear_pin_pullup)
        else $error("pin5 pull-up does not follow the fuse");

    property p_priority6;
        @(posedge clk) disable iff (!resetn)
        altOut.en2[6] |-> pinOut[6] == altOut.val2[6];
    endproperty
    a_priority6: assert property (p_priority6)
        else $error("pin6 top function lost the pin");

    property p_pin5_never_drives;
        @(posedge clk) disable iff (!resetn)
        pinOeN[PIN_MASTER_CLEAR_PIN] && pinOeN[4];
    endproperty
    a_pin5_never_drives: assert property (p_pin5_never_drives)
        else $error("input-only or absent pin driven");

    property p_ioc_analog;
        @(posedge clk) disable iff (!resetn)
        ansel_r[1] |-> !changeEnable[1];
    endproperty
    a_ioc_analog: assert property (p_ioc_analog)
        else $error("change detect left on for analog pin");

    // register state seen at the first edge after each reset release
    property p_dir_reset;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> dir_r == DIR_RESET;
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("direction bits not all inputs after reset");

    property p_ansel_reset;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> ansel_r == ANSEL_RESET;
    endproperty
    a_ansel_reset: assert property (p_ansel_reset)
        else $error("analog select not analog after reset");

    property p_ioc_reset;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> ioc_r == 8'h00;
    endproperty
    a_ioc_reset: assert property (p_ioc_reset)
        else $error("change enables set after reset");

    property p_gpu_reset;
        @(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> gpuDisable_r;
    endproperty
    a_gpu_reset: assert property (p_gpu_reset)
        else $error("global pull-up disable clear after reset");

    // pull-up gating by the global bit and by direction
    property p_global_pullup;
        @(posedge clk) disable iff (!resetn)
        gpuDisable_r |-> pullupOn[3:0] == 4'h0;
    endproperty
    a_global_pullup: assert property (p_global_pullup)
        else $error("pull-up on while globally disabled");

    property p_output_no_pullup;
        @(posedge clk) disable iff (!resetn)
        !dirEff[3] |-> !pullupOn[3];
    endproperty
    a_output_no_pullup: assert property (p_output_no_pullup)
        else $error("pin3 pull-up on while it is an output");

    // read path and digital inputs
    property p_data_bit4;
        @(posedge clk) disable iff (!resetn)
        (clkEn && busReq.rd && busReq.addr == OFF_DATA)
            |=> !rdData[4];
    endproperty
    a_data_bit4: assert property (p_data_bit4)
        else $error("absent data bit read as one");

    property p_digin_analog;
        @(posedge clk) disable iff (!resetn)
        ansel_r[2] |-> !digIn[2];
    endproperty
    a_digin_analog: assert property (p_digin_analog)
        else $error("analog pin2 gave a digital one");

    property p_ioc_digital;
        @(posedge clk) disable iff (!resetn)
        !ansel_r[0] |-> changeEnable[0] == ioc_r[0];
    endproperty
    a_ioc_digital: assert property (p_ioc_digital)
        else $error("pin0 change enable lost while digital");

    // register writes and the driver they control
    property p_dir_write;
        @(posedge clk) disable iff (!resetn)
        (clkEn && wrDir) |=>
            pinOeN[1] == $past(busReq.wdata[1]);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("pin1 driver does not follow its direction bit");

    property p_ioc_write;
        @(posedge clk) disable iff (!resetn)
        (clkEn && wrIoc) |=>
            ioc_r == ($past(busReq.wdata) & 8'hf7);
    endproperty
    a_ioc_write: assert property (p_ioc_write)
        else $error("change enable write stored wrong bits");

    property p_analog_drive;
        @(posedge clk) disable iff (!resetn)
        (ansel_r[1] && !dir_r[1]) |-> !pinOeN[1];
    endproperty
    a_analog_drive: assert property (p_analog_drive)
        else $error("analog select stopped a digital driver");

    // output priority below the top function
    property p_priority2;
        @(posedge clk) disable iff (!resetn)
        (altOut.en1[2] && !altOut.en2[2]) |-> pinOut[2] == altOut.val1[2];
    endproperty
    a_priority2: assert property (p_priority2)
        else $error("pin2 middle function lost the pin");

    property p_port_lowest;
        @(posedge clk) disable iff (!resetn)
        !altOut.en1[0] |-> pinOut[0] == latch_r[0];
    endproperty
    a_port_lowest: assert property (p_port_lowest)
        else $error("pin0 port latch not on the pin");

    // a low clock enable holds the latch and the synchroniser
    property p_clken_freeze;
        @(posedge clk) disable iff (!resetn)
        !clkEn |=> $stable(latch_r) && $stable(sync2_r);
    endproperty
    a_clken_freeze: assert property (p_clken_freeze)
        else $error("state moved while clock enable low");
endmodule

// File: test/pad_model.sv
// pad model: resolves the port a pin levels seen by the chip
`timescale 1ns/1ps
module pad_model (
    input wire logic clk,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOeN,
    input wire logic [7:0] pullupOn,
    input wire logic [7:0] extEn,
    input wire logic [7:0] extVal,
    output logic [7:0] pinLevel
);
    logic [7:0] floatPat = 8'h00;
    // undriven pads wander each cycle so a stale level never passes for a drive
    always @(posedge clk) begin
        floatPat <= ~floatPat;
    end
    // chip drive first, pin7 only sinks; then outside drivers, then pull-ups
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pinOeN[i]) begin
                pinLevel[i] = (i == 7) ? 1'b0 : pinOut[i];
            end else if (extEn[i]) begin
                pinLevel[i] = extVal[i];
            end else if (pullupOn[i]) begin
                pinLevel[i] = 1'b1;
            end else begin
                pinLevel[i] = floatPat[i];
            end
        end
    end
endmodule

// File: test/test_port_a_gpio_with_pin_priority.sv
// self-checking bench for the port a gpio block
`timescale 1ns/1ps
module test_port_a_gpio_with_pin_priority;
    import port_a_pkg::*;
    typedef struct packed {
        logic doWr;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic clkEn = 1'b1;
    reg_req_t busReq = '0;
    alt_out_t altOut = '0;
    logic [7:0] fuseWord = 8'h20;
    logic [7:0] extEn = 8'h00;
    logic [7:0] extVal = 8'h00;
    logic [7:0] rdData, pinIn, pinOut, pinOeN, pullupOn, digIn, changeEnable;
    logic [3:0] analogMode;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    // reset values first, then write and read back
    row_t rows [12] = '{'{1'b0, OFF_DIR, 8'h00, 8'hef}, '{1'b0, OFF_ANSEL, 8'h00, 8'h0f},
        '{1'b0, OFF_IOC, 8'h00, 8'h00}, '{1'b0, OFF_OPTION, 8'h00, 8'h80},
        '{1'b0, OFF_PULLUP, 8'h00, 8'h2f}, '{1'b1, OFF_DIR, 8'h00, 8'h20},
        '{1'b1, OFF_DIR, 8'hff, 8'hef}, '{1'b1, OFF_ANSEL, 8'hff, 8'h0f},
        '{1'b1, OFF_PULLUP, 8'hff, 8'h2f}, '{1'b1, OFF_OPTION, 8'hff, 8'h80},
        '{1'b1, OFF_IOC, 8'hff, 8'hf7}, '{1'b1, 3'h7, 8'hff, 8'h00}};

    always #2 clk = ~clk;

    port_a_gpio port_a_gpio_inst (.clk(clk), .resetn(resetn), .clkEn(clkEn), .busReq(busReq),
        .rdData(rdData), .fuseWord(fuseWord), .altOut(altOut), .pinIn(pinIn),
        .pinOut(pinOut), .pinOeN(pinOeN), .pullupOn(pullupOn), .digIn(digIn),
        .changeEnable(changeEnable), .analogMode(analogMode));
    pad_model pad_model_inst (.clk(clk), .pinOut(pinOut), .pinOeN(pinOeN),
        .pullupOn(pullupOn), .extEn(extEn), .extVal(extVal), .pinLevel(pinIn));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 chk(what, exp, rdData);
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard, well above the hundred-odd cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            $display("CHECK FAILED timeout expected done seen hang");
            results();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        #1 chk("oe after reset", 8'hff, pinOeN);
        chk("change enables after reset", 8'h00, changeEnable);
        chk("pull-ups after reset", 8'h20, pullupOn);
        foreach (rows[i]) begin
            if (rows[i].doWr) begin
                wr(rows[i].addr, rows[i].wdata);
            end
            rd(rows[i].addr, rows[i].exp, "register row");
        end
        // analog pins read zero, then digital reads through the synchroniser
        @(posedge clk);
        extEn <= 8'hff;
        extVal <= 8'hff;
        repeat (3) @(posedge clk);
        rd(OFF_DATA, 8'he0, "analog read");
        chk("digIn analog", 8'he0, digIn);
        chk("change enables analog", 8'hf0, changeEnable);
        wr(OFF_ANSEL, 8'h00);
        repeat (3) @(posedge clk);
        rd(OFF_DATA, 8'hef, "digital read");
        chk("digIn digital", 8'hef, digIn);
        chk("analog mode", 8'h00, {4'h0, analogMode});
        @(posedge clk);
        extVal <= 8'h00;
        rd(OFF_DATA, 8'hef, "sync old");
        rd(OFF_DATA, 8'h00, "sync new");
        // outputs from the latch, pin7 only sinks, pin5 never driven
        @(posedge clk);
        extEn <= 8'h00;
        wr(OFF_DIR, 8'h00);
        wr(OFF_DATA, 8'h4a);
        #1 chk("oe outputs", 8'h30, pinOeN);
        chk("latch out", 8'h4a, pinOut & 8'hcf);
        repeat (3) @(posedge clk);
        rd(OFF_DATA, 8'h6a, "driven read");
        wr(OFF_DATA, 8'h80);
        #1 chk("pin7 released", 8'hb0, pinOeN);
        // analog pins still drive; bit update stores analog zeros
        wr(OFF_DATA, 8'h4a);
        wr(OFF_ANSEL, 8'h0f);
        #1 chk("analog drive", 8'h0a, pinOut & 8'h0f);
        chk("analog oe", 8'h00, pinOeN & 8'h0f);
        repeat (3) @(posedge clk);
        wr(OFF_BITOP, 8'h06);
        #1 chk("bit update", 8'h00, pinOut & 8'hcf);
        repeat (3) @(posedge clk);
        wr(OFF_BITOP, 8'h08);
        #1 chk("bit set", 8'h01, pinOut & 8'hcf);
        // pull-up gating by fuse, global bit, direction, alternate, analog
        @(posedge clk);
        fuseWord <= 8'h00;
        #1 chk("fuse off", 8'h00, pullupOn);
        wr(OFF_OPTION, 8'h00);
        wr(OFF_ANSEL, 8'h00);
        wr(OFF_DIR, 8'hff);
        #1 chk("pull-ups on", 8'h0f, pullupOn);
        @(posedge clk);
        fuseWord <= 8'h20;
        #1 chk("fuse on", 8'h2f, pullupOn);
        wr(OFF_DIR, 8'hfe);
        #1 chk("output kills", 8'h2e, pullupOn);
        @(posedge clk);
        altOut.en1 <= 8'h02;
        #1 chk("alternate kills", 8'h2c, pullupOn);
        wr(OFF_ANSEL, 8'h04);
        #1 chk("analog kills", 8'h28, pullupOn);
        wr(OFF_OPTION, 8'h80);
        #1 chk("global kills", 8'h20, pullupOn);
        // output priority per pin
        wr(OFF_ANSEL, 8'h00);
        wr(OFF_DIR, 8'h00);
        wr(OFF_DATA, 8'h00);
        @(posedge clk);
        altOut <= '{en1: 8'he7, val1: 8'hff, en2: 8'h00, val2: 8'h00};
        #1 chk("level one", 8'hc7, pinOut & 8'hc7);
        @(posedge clk);
        altOut.en2 <= 8'h64;
        #1 chk("level two", 8'h83, pinOut & 8'hc7);
        // a write while the clock enable is low must be lost
        @(posedge clk);
        clkEn <= 1'b0;
        wr(OFF_DIR, 8'hff);
        clkEn <= 1'b1;
        rd(OFF_DIR, 8'h20, "frozen write");
        @(posedge clk);
        #1 chk("read data drop", 8'h00, rdData);
        // second reset in mid-run brings back the defaults
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        #1 chk("oe after second reset", 8'hff, pinOeN);
        chk("analog after second reset", 8'h0f, {4'h0, analogMode});
        chk("pull-ups after second reset", 8'h20, pullupOn);
        rd(OFF_IOC, 8'h00, "change enables after second reset");
        rd(OFF_DIR, 8'hef, "direction after second reset");
        results();
    end
endmodule
